// >>> sar_cfg.svh
// constants for the alert response responder
// assumes a 200 MHz core clock and an slow i2c bus sampled by it
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

`define SAR_ARA_ADDR   7'h0C
`define SAR_OWN_ADDR   7'h64
`define SAR_ADDR_BITS  4'd7
`define SAR_BYTE_BITS  4'd8

`endif

// >>> sar_pkg.sv
// types for the alert response responder
// assumes the constants header is included by the design file
package sar_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } sar_bus_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } sar_bus_out_t;

  typedef enum logic [5:0] {
    SAR_IDLE  = 6'b000001,
    SAR_RXADR = 6'b000010,
    SAR_ACK   = 6'b000100,
    SAR_TX    = 6'b001000,
    SAR_MACK  = 6'b010000,
    SAR_WAIT  = 6'b100000
  } sar_state_t;

endpackage

// >>> sar_responder.sv
// alert response responder: answers the alert response address
// assumes scl/sda pins are open drain with external pull-ups
// Operation
// - alerting device acks, sends own address, one
// - sampled zero while sending one: stop driving
// - after lost arbitration, alert stays; retry later
// - clean send releases the alert output
// - after success ignore until new alert event
// - only pull lines low, never drive high
`timescale 1ns/1ps
`include "sar_cfg.svh"

module sar_responder (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire sar_pkg::sar_bus_in_t  bus_in,
  input  wire logic                  alert_event,
  output      sar_pkg::sar_bus_out_t bus_out,
  output      logic                  alert_output_pin_o,
  output      logic                  alert_output_pin_oe
);
  import sar_pkg::*;

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus_in.scl};
      sda_sync_q <= {sda_sync_q[0], bus_in.sda};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_sync_q[1] & ~scl_q;
  assign scl_fall  = ~scl_sync_q[1] & scl_q;
  // both conditions only while scl stays high
  assign start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  assign stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

  // ****************************************************
  // alert flag
  // ****************************************************
  logic alert_q;
  logic win_pulse;

  // a new event wins over a release in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else if (alert_event) begin
      alert_q <= 1'b1;
    end else if (win_pulse) begin
      alert_q <= 1'b0;
    end
  end

  // open drain: output value is always low
  assign alert_output_pin_o  = 1'b0;
  assign alert_output_pin_oe = alert_q;

  // ****************************************************
  // protocol engine
  // ****************************************************
  sar_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic       drive_low_q;
  logic       win_q;
  logic [7:0] tx_byte;

  assign tx_byte   = {`SAR_OWN_ADDR, 1'b1};
  assign win_pulse = win_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q     <= SAR_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      drive_low_q <= 1'b0;
      win_q       <= 1'b0;
    end else begin
      win_q <= 1'b0;
      if (start_det) begin
        state_q     <= SAR_RXADR;
        bit_cnt_q   <= 4'h0;
        drive_low_q <= 1'b0;
      end else if (stop_det) begin
        state_q     <= SAR_IDLE;
        drive_low_q <= 1'b0;
      end else begin
        unique case (state_q)
          SAR_IDLE, SAR_WAIT: begin
            drive_low_q <= 1'b0;
          end
          SAR_RXADR: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_fall && bit_cnt_q == `SAR_BYTE_BITS) begin
              if (shift_q == {`SAR_ARA_ADDR, 1'b1} && alert_q) begin
                state_q     <= SAR_ACK;
                drive_low_q <= 1'b1;
              end else begin
                state_q <= SAR_WAIT;
              end
            end
          end
          SAR_ACK: begin
            if (scl_fall) begin
              state_q     <= SAR_TX;
              bit_cnt_q   <= 4'h0;
              drive_low_q <= ~tx_byte[7];
            end
          end
          SAR_TX: begin
            if (scl_rise) begin
              if (!drive_low_q && !sda_q) begin
                // another device owns the bus; alert kept
                state_q     <= SAR_WAIT;
                drive_low_q <= 1'b0;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
            if (scl_fall) begin
              if (bit_cnt_q == `SAR_BYTE_BITS) begin
                state_q     <= SAR_MACK;
                drive_low_q <= 1'b0;
                win_q       <= 1'b1;
              end else begin
                drive_low_q <= ~tx_byte[3'd7 - bit_cnt_q[2:0]];
              end
            end
          end
          SAR_MACK: begin
            drive_low_q <= 1'b0;
            if (scl_fall) begin
              state_q <= SAR_WAIT;
            end
          end
        endcase
      end
    end
  end

  assign bus_out.sda_o  = 1'b0;
  assign bus_out.sda_oe = drive_low_q;

endmodule

// >>> sar_responder_asserts.sv
// port checker for the alert responder
// assumes binding onto sar_responder
`timescale 1ns/1ps
module sar_responder_asserts (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire sar_pkg::sar_bus_in_t  bus_in,
  input wire logic                  alert_event,
  input wire sar_pkg::sar_bus_out_t bus_out,
  input wire logic                  alert_output_pin_o,
  input wire logic                  alert_output_pin_oe
);
  import sar_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence off2;
    !alert_output_pin_oe ##1 !alert_output_pin_oe;
  endsequence
  a_sda_pull: assert property (
    !bus_out.sda_o) else $error("sda high");
  a_alert_pull: assert property (
    !alert_output_pin_o) else $error("alert high");
  a_ack_alert: assert property (
    $rose(bus_out.sda_oe) |-> alert_output_pin_oe) else $error("bad ack");
  a_event_sets: assert property (
    alert_event |=> alert_output_pin_oe) else $error("no alert");
  a_release_late: assert property (
    $fell(alert_output_pin_oe) |-> !bus_out.sda_oe) else $error("early");
  a_alert_held: assert property (
    alert_output_pin_oe ##1 bus_in.scl [*6] |=> alert_output_pin_oe)
    else $error("alert lost");
  a_quiet_off: assert property (
    off2 |-> !bus_out.sda_oe) else $error("sda driven");
  a_sda_scl_low: assert property (
    $changed(bus_out.sda_oe) |-> !bus_in.scl) else $error("sda moved");
endmodule

// >>> sar_host_model.sv
// bus host model polling the alert response address
// assumes pull-ups; a rival slave may pull sda too
`timescale 1ns/1ps
module sar_host_model (
  output logic     scl,
  output logic     sda,
  input wire logic dev_oe
);
  logic m_low = 1'h0;
  logic r_low = 1'h0;
  initial scl = 1'h1;
  assign sda = !(m_low | r_low | dev_oe);
  task automatic bit_io(input logic b, input logic r, output logic s);
    #16 m_low = !b;
    r_low = !r;
    #16 scl = 1'h1;
    #16 s = sda;
    #16 scl = 1'h0;
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] rv,
                      output logic [7:0] rd, output logic ack);
    logic x;
    logic lost;
    lost = 1'h0;
    m_low = 1'h1;
    #16 scl = 1'h0;
    for (int i = 7; i >= 0; i--) bit_io(a[i], 1'h1, x);
    bit_io(1'h1, 1'h1, ack);
    // rival backs off once it sees a zero against its own one
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, rv[i] | lost, rd[i]);
      if (rv[i] && !rd[i]) lost = 1'h1;
    end
    bit_io(1'h1, 1'h1, x);
    #16 m_low = 1'h1;
    #16 scl = 1'h1;
    #16 m_low = 1'h0;
    #32;
  endtask
endmodule

// >>> sar_responder_tb_top.sv
// bench for the alert responder
// assumes the host model; rival bits are random except in the first round, where the rival sends 8'hFF
`timescale 1ns/1ps
module sar_responder_tb_top;
  import sar_pkg::*;
  logic         core_clk;
  logic         rst;
  logic         alert_event;
  logic         scl;
  logic         sda;
  logic         aoe;
  logic [31:0]  seed = 32'h917B;
  int           error_cnt;
  int           total_checks;
  sar_bus_out_t bus_out;
  logic [9:0]   q[$];
  logic [9:0]   res;
  logic [9:0]   ex;
  event         got;
  `define CHK(e, g) total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR poll exp %h got %h", e, g); end
  sar_host_model host (.scl(scl), .sda(sda), .dev_oe(bus_out.sda_oe));
  sar_responder dut (.core_clk(core_clk), .rst(rst), .bus_in({scl, sda}),
    .alert_event(alert_event), .bus_out(bus_out),
    .alert_output_pin_o(), .alert_output_pin_oe(aoe));
  task automatic poll(input logic [7:0] a, input logic [7:0] r,
                      input logic [9:0] e);
    logic [7:0] rd;
    logic       ack;
    q.push_back(e);
    host.poll(a, r, rd, ack);
    res = {ack, rd, aoe};
    ->got;
  endtask
  always @(got) begin
    ex = q.pop_front();
    `CHK(ex, res)
  end
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #200000 error_cnt++;
    conclude();
  end
  initial begin
    logic [7:0] r;
    rst = 1'h1;
    alert_event = 1'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    poll(8'h19, 8'hFF, 10'h3FE);
    for (int i = 0; i < 6; i++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      r = i ? seed[7:0] : 8'hFF;
      @(posedge core_clk) alert_event <= 1'h1;
      @(posedge core_clk) alert_event <= 1'h0;
      poll(8'h18, 8'hFF, 10'h3FF);
      // the lower address wins; the wire shows the winner alone
      poll(8'h19, r, {1'h0, r < 8'hC9 ? r : 8'hC9, r < 8'hC9});
      if (r < 8'hC9) poll(8'h19, 8'hFF, 10'h192);
      poll(8'h19, 8'hFF, 10'h3FE);
    end
    conclude();
  end
endmodule
bind sar_responder sar_responder_asserts chk (.core_clk(core_clk),
  .rst(rst), .bus_in(bus_in), .alert_event(alert_event),
  .bus_out(bus_out), .alert_output_pin_o(alert_output_pin_o),
  .alert_output_pin_oe(alert_output_pin_oe));
